//--- core/frss_params.svh
// Register offsets, status word field positions, reset values and latencies.
`ifndef FRSS_PARAMS_SVH
`define FRSS_PARAMS_SVH

`define FRSS_ADDR_W      4
`define FRSS_OFF_STATUS  4'h0
`define FRSS_OFF_TAG     4'h1
`define FRSS_OFF_MASK    4'h2

`define FRSS_SW_BUSY     15
`define FRSS_SW_C3       14
`define FRSS_SW_TOP_HI   13
`define FRSS_SW_TOP_LO   11
`define FRSS_SW_C2       10
`define FRSS_SW_C1       9
`define FRSS_SW_C0       8
`define FRSS_SW_ES       7
`define FRSS_SW_SF       6
`define FRSS_SW_EXC_HI   5
`define FRSS_EXC_INVALID 0

`define FRSS_TOP_RST     3'h0
`define FRSS_CC_RST      4'h0
`define FRSS_EXC_RST     6'h00
`define FRSS_MASK_RST    6'h3F
`define FRSS_TAG_RST     16'hFFFF

`define FRSS_RES_LAT     2

`endif

//--- core/frss_pkg.sv
// Types shared by the register stack and status block.
package frss_pkg;

    typedef enum logic [3:0] {
        FRSS_OP_NOP     = 4'h0,
        FRSS_OP_PUSH    = 4'h1,
        FRSS_OP_POP     = 4'h2,
        FRSS_OP_READ    = 4'h3,
        FRSS_OP_WRITE   = 4'h4,
        FRSS_OP_ARITH   = 4'h5,
        FRSS_OP_COMPARE = 4'h6,
        FRSS_OP_PREM    = 4'h7,
        FRSS_OP_EXAMINE = 4'h8,
        FRSS_OP_INCTOP  = 4'h9,
        FRSS_OP_DECTOP  = 4'hA,
        FRSS_OP_FREE    = 4'hB,
        FRSS_OP_CLEX    = 4'hC,
        FRSS_OP_INIT    = 4'hD
    } frss_op_t;

    typedef enum logic [1:0] {
        FRSS_TAG_VALID   = 2'h0,
        FRSS_TAG_ZERO    = 2'h1,
        FRSS_TAG_SPECIAL = 2'h2,
        FRSS_TAG_EMPTY   = 2'h3
    } frss_tag_t;

    typedef enum logic [1:0] {
        FRSS_CMP_GT    = 2'h0,
        FRSS_CMP_LT    = 2'h1,
        FRSS_CMP_EQ    = 2'h2,
        FRSS_CMP_UNORD = 2'h3
    } frss_cmp_t;

endpackage : frss_pkg

//--- core/frss_mem_if.sv
// Write and read port bundle between the stack control and the data register array.
`timescale 1ns/10ps
interface frss_mem_if #(
    parameter int DATA_W = 80,
    parameter int IDX_W  = 3
);
    logic              wr_en;
    logic [IDX_W-1:0]  wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic              rd_en;
    logic [IDX_W-1:0]  rd_addr;
    logic [DATA_W-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_en, input rd_addr, output rd_data);
endinterface : frss_mem_if

//--- core/frss_data_ram.sv
// Array of data registers with a registered read port.
`timescale 1ns/10ps
module frss_data_ram #(
    parameter int DATA_W = 80,
    parameter int DEPTH  = 8
) (
    input  wire logic CLK,
    input  wire logic RST_N,
    frss_mem_if.mem   port
);
    logic [DATA_W-1:0] store_reg [DEPTH];
    logic [DATA_W-1:0] rd_data_reg;

    // The array has no reset; the tag word tells which entries hold data.
    always_ff @(posedge CLK) begin
        if (port.wr_en) begin
            store_reg[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rd_data_reg <= '0;
        end else if (port.rd_en) begin
            rd_data_reg <= store_reg[port.rd_addr];
        end
    end

    assign port.rd_data = rd_data_reg;

endmodule : frss_data_ram

//--- core/frss_top.sv
// Numeric coprocessor data register stack, tag word and status word.
//
// Functional notes
// - Eight 80-bit data registers, used as a stack or by index.
// - Push decrements the top pointer, then writes the new top register.
// - Pop delivers the current top value, then increments the top pointer.
// - Implicit addressing selects the register the top pointer names.
// - Explicit register indices count from the top pointer.
// - Tag word holds a two-bit tag for each of the eight registers.
// - Tags separate empty from occupied registers without decoding data.
// - A 16-bit status word reflects overall state and is readable.
// - Status bit 15 mirrors the error summary bit 7, not busy.
// - Status bits 13 to 11 hold the physical top register index.
// - Arithmetic instructions update the four condition code bits.
// - Error summary is set exactly when an unmasked exception flag is set.
// - The error output is asserted while the error summary is set.
// - Stack fault flag marks invalid operation from stack overflow or underflow.
// - With stack fault set, bit 9 is 1 for overflow, 0 underflow.
// - Six exception flags in bits 5 to 0 are set on detected exceptions.
// - Loaded status recomputes summary and mirror from flags and masks.
// - A summary set by a status load asserts the error output at once.
// - Remainder sets C2 when incomplete, else C0, C3, C1 get quotient bits.
// - Compare codes C3 C2 C0: 000 greater, 001 less, 100 equal, 111 unordered.
`timescale 1ns/10ps
`include "frss_params.svh"
module frss_top #(
    parameter int DATA_W = 80,
    parameter int BUS_W  = 16
) (
    input  wire logic                    CLK,
    input  wire logic                    RST_N,
    input  wire logic [`FRSS_ADDR_W-1:0] ADDR,
    input  wire logic [BUS_W-1:0]        WDATA,
    input  wire logic                    WR,
    input  wire logic                    RD,
    output logic      [BUS_W-1:0]        RDATA,
    input  wire logic                    CMD_VALID,
    input  wire logic [3:0]              CMD_OP,
    input  wire logic [2:0]              CMD_IDX,
    input  wire logic [DATA_W-1:0]       CMD_DATA,
    input  wire logic [1:0]              CMD_TAG,
    input  wire logic [5:0]              CMD_EXC,
    input  wire logic [3:0]              CMD_CC,
    output logic      [DATA_W-1:0]       RES_DATA,
    output logic                         RES_VALID,
    output logic                         ERROR_N
);

    // Status word state; condition codes are held as {C3, C2, C1, C0}.
    logic [2:0]        top_reg;
    logic [2:0]        top_next;
    logic [3:0]        cc_reg;
    logic [3:0]        cc_next;
    logic              sf_reg;
    logic              sf_next;
    logic [5:0]        exc_reg;
    logic [5:0]        exc_next;
    logic [5:0]        mask_reg;
    logic [5:0]        mask_next;
    logic [15:0]       tag_reg;
    logic [15:0]       tag_next;
    logic              es_now;
    logic              es_next;
    logic [BUS_W-1:0]  rdata_reg;
    logic              res_pend_reg;
    logic              res_valid_reg;
    logic [DATA_W-1:0] res_data_reg;
    logic              error_n_reg;
    logic [2:0]        rel_idx;
    logic [2:0]        dec_idx;
    logic [2:0]        inc_idx;

    frss_pkg::frss_op_t  cmd_op;
    frss_pkg::frss_cmp_t cmp_code;

    frss_mem_if #(.DATA_W(DATA_W), .IDX_W(3)) mem_bus ();

    function automatic logic [2:0] frss_rel_phys(input logic [2:0] top,
                                                 input logic [2:0] idx);
        frss_rel_phys = 3'(top + idx);
    endfunction : frss_rel_phys

    function automatic frss_pkg::frss_tag_t frss_tag_of(input logic [15:0] tw,
                                                        input logic [2:0]  idx);
        frss_tag_of = frss_pkg::frss_tag_t'(tw[{idx, 1'b0} +: 2]);
    endfunction : frss_tag_of

    // Empty is judged by tag alone.
    function automatic logic frss_is_empty(input logic [15:0] tw,
                                           input logic [2:0]  idx);
        frss_is_empty = (frss_tag_of(tw, idx) == frss_pkg::FRSS_TAG_EMPTY);
    endfunction : frss_is_empty

    assign cmd_op   = frss_pkg::frss_op_t'(CMD_OP);
    assign cmp_code = frss_pkg::frss_cmp_t'(CMD_CC[1:0]);
    assign rel_idx  = frss_rel_phys(top_reg, CMD_IDX);
    assign dec_idx  = 3'(top_reg - 3'h1);
    assign inc_idx  = 3'(top_reg + 3'h1);
    assign es_now   = |(exc_reg & ~mask_reg);

    frss_data_ram #(
        .DATA_W (DATA_W),
        .DEPTH  (8)
    ) u_ram (
        .CLK   (CLK),
        .RST_N (RST_N),
        .port  (mem_bus.mem)
    );

    // Bus loads apply first; a command in the same cycle is layered on top,
    // so exception flags it raises are never lost to a status load.
    always_comb begin
        top_next          = top_reg;
        cc_next           = cc_reg;
        sf_next           = sf_reg;
        exc_next          = exc_reg;
        mask_next         = mask_reg;
        tag_next          = tag_reg;
        mem_bus.wr_en     = 1'b0;
        mem_bus.wr_addr   = top_reg;
        mem_bus.wr_data   = CMD_DATA;
        mem_bus.rd_en     = 1'b0;
        mem_bus.rd_addr   = top_reg;

        if (WR && ADDR == `FRSS_OFF_STATUS) begin
            // Bits 15 and 7 of the image are ignored and recomputed.
            top_next = WDATA[`FRSS_SW_TOP_HI:`FRSS_SW_TOP_LO];
            cc_next  = {WDATA[`FRSS_SW_C3], WDATA[`FRSS_SW_C2],
                        WDATA[`FRSS_SW_C1], WDATA[`FRSS_SW_C0]};
            sf_next  = WDATA[`FRSS_SW_SF];
            exc_next = WDATA[`FRSS_SW_EXC_HI:0];
        end else if (WR && ADDR == `FRSS_OFF_TAG) begin
            tag_next = WDATA[15:0];
        end else if (WR && ADDR == `FRSS_OFF_MASK) begin
            mask_next = WDATA[5:0];
        end

        if (CMD_VALID) begin
            case (cmd_op)
                frss_pkg::FRSS_OP_PUSH: begin
                    if (!frss_is_empty(tag_reg, dec_idx)) begin
                        exc_next[`FRSS_EXC_INVALID] = 1'b1;
                        sf_next                     = 1'b1;
                        cc_next[1]                  = 1'b1;
                    end else begin
                        top_next                    = dec_idx;
                        mem_bus.wr_en               = 1'b1;
                        mem_bus.wr_addr             = dec_idx;
                        tag_next[{dec_idx, 1'b0} +: 2] = CMD_TAG;
                        cc_next[1]                  = 1'b0;
                    end
                end
                frss_pkg::FRSS_OP_POP: begin
                    if (frss_is_empty(tag_reg, top_reg)) begin
                        exc_next[`FRSS_EXC_INVALID] = 1'b1;
                        sf_next                     = 1'b1;
                        cc_next[1]                  = 1'b0;
                    end else begin
                        // The read address is taken this cycle, before the move.
                        mem_bus.rd_en               = 1'b1;
                        tag_next[{top_reg, 1'b0} +: 2] = frss_pkg::FRSS_TAG_EMPTY;
                        top_next                    = inc_idx;
                        cc_next[1]                  = 1'b0;
                    end
                end
                frss_pkg::FRSS_OP_READ: begin
                    if (frss_is_empty(tag_reg, rel_idx)) begin
                        exc_next[`FRSS_EXC_INVALID] = 1'b1;
                        sf_next                     = 1'b1;
                        cc_next[1]                  = 1'b0;
                    end else begin
                        mem_bus.rd_en               = 1'b1;
                        mem_bus.rd_addr             = rel_idx;
                    end
                end
                frss_pkg::FRSS_OP_WRITE: begin
                    mem_bus.wr_en                   = 1'b1;
                    mem_bus.wr_addr                 = rel_idx;
                    tag_next[{rel_idx, 1'b0} +: 2]  = CMD_TAG;
                end
                frss_pkg::FRSS_OP_ARITH: begin
                    exc_next = exc_next | CMD_EXC;
                    cc_next  = CMD_CC;
                end
                frss_pkg::FRSS_OP_COMPARE: begin
                    exc_next   = exc_next | CMD_EXC;
                    cc_next[1] = 1'b0;
                    case (cmp_code)
                        frss_pkg::FRSS_CMP_GT: begin
                            {cc_next[3], cc_next[2], cc_next[0]} = 3'h0;
                        end
                        frss_pkg::FRSS_CMP_LT: begin
                            {cc_next[3], cc_next[2], cc_next[0]} = 3'h1;
                        end
                        frss_pkg::FRSS_CMP_EQ: begin
                            {cc_next[3], cc_next[2], cc_next[0]} = 3'h4;
                        end
                        default: begin
                            {cc_next[3], cc_next[2], cc_next[0]} = 3'h7;
                        end
                    endcase
                end
                frss_pkg::FRSS_OP_PREM: begin
                    // CMD_CC[3] flags incomplete reduction, CMD_CC[2:0] is the quotient.
                    exc_next   = exc_next | CMD_EXC;
                    cc_next[2] = CMD_CC[3];
                    if (!CMD_CC[3]) begin
                        cc_next[0] = CMD_CC[2];
                        cc_next[3] = CMD_CC[1];
                        cc_next[1] = CMD_CC[0];
                    end
                end
                frss_pkg::FRSS_OP_EXAMINE: begin
                    // An empty top is classed from the tag alone; the sign still comes in.
                    if (frss_is_empty(tag_reg, top_reg)) begin
                        cc_next = {1'b1, 1'b0, CMD_CC[1], 1'b1};
                    end else begin
                        cc_next = CMD_CC;
                    end
                end
                frss_pkg::FRSS_OP_INCTOP: begin
                    top_next = inc_idx;
                end
                frss_pkg::FRSS_OP_DECTOP: begin
                    top_next = dec_idx;
                end
                frss_pkg::FRSS_OP_FREE: begin
                    tag_next[{rel_idx, 1'b0} +: 2] = frss_pkg::FRSS_TAG_EMPTY;
                end
                frss_pkg::FRSS_OP_CLEX: begin
                    exc_next = CMD_EXC;
                    sf_next  = 1'b0;
                end
                frss_pkg::FRSS_OP_INIT: begin
                    top_next  = `FRSS_TOP_RST;
                    cc_next   = `FRSS_CC_RST;
                    sf_next   = 1'b0;
                    exc_next  = `FRSS_EXC_RST;
                    mask_next = `FRSS_MASK_RST;
                    tag_next  = `FRSS_TAG_RST;
                end
                default: begin
                    top_next = top_next;
                end
            endcase
        end

        es_next = |(exc_next & ~mask_next);
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            top_reg <= `FRSS_TOP_RST;
        end else begin
            top_reg <= top_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cc_reg <= `FRSS_CC_RST;
        end else begin
            cc_reg <= cc_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sf_reg  <= 1'b0;
            exc_reg <= `FRSS_EXC_RST;
        end else begin
            sf_reg  <= sf_next;
            exc_reg <= exc_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mask_reg <= `FRSS_MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tag_reg <= `FRSS_TAG_RST;
        end else begin
            tag_reg <= tag_next;
        end
    end

    // Driven from the next-state summary so a status load shows on the pin
    // in the same edge that stores the flags.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            error_n_reg <= 1'b1;
        end else begin
            error_n_reg <= ~es_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdata_reg <= '0;
        end else if (RD && ADDR == `FRSS_OFF_STATUS) begin
            rdata_reg <= BUS_W'({es_now, cc_reg[3], top_reg, cc_reg[2], cc_reg[1],
                                 cc_reg[0], es_now, sf_reg, exc_reg});
        end else if (RD && ADDR == `FRSS_OFF_TAG) begin
            rdata_reg <= BUS_W'(tag_reg);
        end else if (RD && ADDR == `FRSS_OFF_MASK) begin
            rdata_reg <= BUS_W'(mask_reg);
        end else if (RD) begin
            rdata_reg <= '0;
        end
    end

    // Register value leaves two edges after the command: array read, then output.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            res_pend_reg  <= 1'b0;
            res_valid_reg <= 1'b0;
            res_data_reg  <= '0;
        end else begin
            res_pend_reg  <= mem_bus.rd_en;
            res_valid_reg <= res_pend_reg;
            if (res_pend_reg) begin
                res_data_reg <= mem_bus.rd_data;
            end
        end
    end

    assign RDATA     = rdata_reg;
    assign RES_DATA  = res_data_reg;
    assign RES_VALID = res_valid_reg;
    assign ERROR_N   = error_n_reg;

endmodule : frss_top

//--- verification/frss_top_assertions.sv
// Port checker for the register stack and status block, with its bind.
`timescale 1ns/10ps
`include "frss_params.svh"
module frss_top_assertions #(
    parameter int DATA_W = 80,
    parameter int BUS_W  = 16
) (
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire logic [3:0]        ADDR,
    input wire logic [BUS_W-1:0]  WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [BUS_W-1:0]  RDATA,
    input wire logic              CMD_VALID,
    input wire logic [3:0]        CMD_OP,
    input wire logic [2:0]        CMD_IDX,
    input wire logic [DATA_W-1:0] CMD_DATA,
    input wire logic [1:0]        CMD_TAG,
    input wire logic [5:0]        CMD_EXC,
    input wire logic [3:0]        CMD_CC,
    input wire logic [DATA_W-1:0] RES_DATA,
    input wire logic              RES_VALID,
    input wire logic              ERROR_N
);
    // Mask shadow; the mask shows on RDATA only after a read of its offset.
    logic [5:0] mask_sh;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mask_sh <= 6'h3F;
        end else if (CMD_VALID && CMD_OP == 4'hD) begin
            mask_sh <= 6'h3F;
        end else if (WR && ADDR == `FRSS_OFF_MASK) begin
            mask_sh <= WDATA[5:0];
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_reset_quiet: assert property (disable iff (1'b0) !RST_N |=> !RES_VALID && ERROR_N)
        else $error("outputs not quiet after reset");
    a_result_cause: assert property (RES_VALID |-> $past(CMD_VALID, 2) &&
        ($past(CMD_OP, 2) == 4'h2 || $past(CMD_OP, 2) == 4'h3))
        else $error("result without a pop or read two cycles before");
    a_busy_mirror: assert property (RD && ADDR == `FRSS_OFF_STATUS |=> RDATA[15] == RDATA[7])
        else $error("busy mirror differs from error summary");
    a_error_pin: assert property (RD && ADDR == `FRSS_OFF_STATUS && !WR && !CMD_VALID
        |=> RDATA[7] == !ERROR_N)
        else $error("error output disagrees with summary");
    a_load_sets_err: assert property (WR && ADDR == `FRSS_OFF_STATUS && !CMD_VALID
        && (WDATA[5:0] & ~mask_sh) != 6'h00 |=> !ERROR_N)
        else $error("status load with unmasked flag left error high");
    a_load_clr_err: assert property (WR && ADDR == `FRSS_OFF_STATUS && !CMD_VALID
        && (WDATA[5:0] & ~mask_sh) == 6'h00 |=> ERROR_N)
        else $error("status load without unmasked flag set error");
    a_err_has_cause: assert property ($fell(ERROR_N) |-> $past(WR) || $past(CMD_VALID))
        else $error("error output fell without a cause");
    a_rdata_holds: assert property (!RD |=> $stable(RDATA))
        else $error("read data changed without a read");
    a_mask_upper: assert property (RD && ADDR == `FRSS_OFF_MASK |=> RDATA[15:6] == 10'h000)
        else $error("mask upper bits not zero");
    a_unmapped_zero: assert property (RD && ADDR > `FRSS_OFF_MASK |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    c_result: cover property (RES_VALID);
    c_error: cover property (!ERROR_N);
    c_compare: cover property (CMD_VALID && CMD_OP == 4'h6);
endmodule : frss_top_assertions

bind frss_top frss_top_assertions #(.DATA_W(DATA_W), .BUS_W(BUS_W)) frss_top_assertions_i (
    .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_IDX(CMD_IDX), .CMD_DATA(CMD_DATA),
    .CMD_TAG(CMD_TAG), .CMD_EXC(CMD_EXC), .CMD_CC(CMD_CC), .RES_DATA(RES_DATA),
    .RES_VALID(RES_VALID), .ERROR_N(ERROR_N));

//--- verification/frss_host_model.sv
// Host side model that issues numeric commands to the block.
`timescale 1ns/10ps
module frss_host_model (
    input  wire logic CLK,
    output logic        CMD_VALID,
    output logic [3:0]  CMD_OP,
    output logic [2:0]  CMD_IDX,
    output logic [79:0] CMD_DATA,
    output logic [1:0]  CMD_TAG,
    output logic [5:0]  CMD_EXC,
    output logic [3:0]  CMD_CC
);
    initial begin
        CMD_VALID = 1'b0;
        CMD_OP = 4'h0;
        CMD_IDX = 3'h0;
        CMD_DATA = 80'h0;
        CMD_TAG = 2'h0;
        CMD_EXC = 6'h00;
        CMD_CC = 4'h0;
    end
    // Released fields are inverted, so a stale value never looks held.
    task automatic issue(input logic [3:0] op, input logic [2:0] idx, input logic [79:0] dat,
                         input logic [1:0] tag, input logic [5:0] exc, input logic [3:0] cc);
        @(posedge CLK);
        CMD_VALID <= 1'b1;
        CMD_OP <= op;
        CMD_IDX <= idx;
        CMD_DATA <= dat;
        CMD_TAG <= tag;
        CMD_EXC <= exc;
        CMD_CC <= cc;
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        CMD_OP <= ~op;
        CMD_IDX <= ~idx;
        CMD_DATA <= ~dat;
        CMD_TAG <= ~tag;
        CMD_EXC <= ~exc;
        CMD_CC <= ~cc;
    endtask : issue
endmodule : frss_host_model

//--- verification/frss_top_test.sv
// Self-checking bench for the register stack and status block.
`timescale 1ns/10ps
module frss_top_test;
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [15:0] RDATA;
    logic        CMD_VALID;
    logic [3:0]  CMD_OP;
    logic [2:0]  CMD_IDX;
    logic [79:0] CMD_DATA;
    logic [1:0]  CMD_TAG;
    logic [5:0]  CMD_EXC;
    logic [3:0]  CMD_CC;
    logic [79:0] RES_DATA;
    logic        RES_VALID;
    logic        ERROR_N;
    int          bad_count = 0;
    int          comparisons = 0;
    logic [15:0] rv;
    logic [79:0] va = 80'h3FFF_8000_0000_0000_1234;
    logic [79:0] vb = 80'hC000_C000_0000_0000_5678;

    always #12.5 CLK = ~CLK;

    frss_top frss_top_i (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_IDX(CMD_IDX),
        .CMD_DATA(CMD_DATA), .CMD_TAG(CMD_TAG), .CMD_EXC(CMD_EXC), .CMD_CC(CMD_CC),
        .RES_DATA(RES_DATA), .RES_VALID(RES_VALID), .ERROR_N(ERROR_N));
    frss_host_model frss_host_model_i (.CLK(CLK), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
        .CMD_IDX(CMD_IDX), .CMD_DATA(CMD_DATA), .CMD_TAG(CMD_TAG), .CMD_EXC(CMD_EXC),
        .CMD_CC(CMD_CC));

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16
    task automatic chk80(input string what, input logic [79:0] exp, input logic [79:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk80
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd
    task automatic cmd(input logic [3:0] op, input logic [2:0] idx, input logic [79:0] dat,
                       input logic [1:0] tag, input logic [5:0] exc, input logic [3:0] cc);
        frss_host_model_i.issue(op, idx, dat, tag, exc, cc);
        #1;
    endtask : cmd
    // The result stands one cycle, from the edge after the command edge.
    task automatic expect_res(input logic hit, input logic [79:0] exp);
        @(posedge CLK);
        #1;
        chk16("res_valid", {15'h0000, hit}, {15'h0000, RES_VALID});
        if (hit) begin
            chk80("res_data", exp, RES_DATA);
        end
    endtask : expect_res
    task automatic chk_status(input logic [15:0] exp, input logic [15:0] m);
        rd(4'h0, rv);
        chk16("status", exp, rv & m);
    endtask : chk_status
    task automatic chk_reg(input string what, input logic [3:0] a, input logic [15:0] exp);
        rd(a, rv);
        chk16(what, exp, rv);
    endtask : chk_reg
    task automatic chk_err(input logic exp);
        chk16("error_n", {15'h0000, exp}, {15'h0000, ERROR_N});
    endtask : chk_err
    task automatic do_reset();
        @(posedge CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
    endtask : do_reset

    task automatic t_reset();
        chk_status(16'h0000, 16'hFFFF);
        chk_reg("tag", 4'h1, 16'hFFFF);
        chk_reg("mask", 4'h2, 16'h003F);
        chk_err(1'b1);
    endtask : t_reset
    task automatic t_stack();
        cmd(4'h1, 3'h0, va, 2'h0, 6'h00, 4'h0);
        cmd(4'h1, 3'h0, vb, 2'h1, 6'h00, 4'h0);
        chk_status(16'h3000, 16'h3800);
        chk_reg("tag", 4'h1, 16'h1FFF);
        cmd(4'h3, 3'h1, 80'h0, 2'h0, 6'h00, 4'h0);
        expect_res(1'b1, va);
        cmd(4'h3, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        expect_res(1'b1, vb);
        cmd(4'h2, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        expect_res(1'b1, vb);
        chk_status(16'h3800, 16'h3800);
        cmd(4'h4, 3'h2, vb, 2'h0, 6'h00, 4'h0);
        chk_reg("tag", 4'h1, 16'h3FF3);
    endtask : t_stack
    task automatic t_fault();
        for (int i = 0; i < 8; i++) begin
            cmd(4'h1, 3'h0, va + 80'(i), 2'(i % 4), 6'h00, 4'h0);
        end
        chk_reg("tag", 4'h1, 16'h1B1B);
        cmd(4'h1, 3'h0, vb, 2'h0, 6'h00, 4'h0);
        chk_status(16'h0241, 16'hFFFF);
        chk_err(1'b1);
        cmd(4'hC, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        cmd(4'h2, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        expect_res(1'b0, 80'h0);
        chk_status(16'h0041, 16'hFFFF);
    endtask : t_fault
    task automatic t_load();
        wr(4'h2, 16'h003E);
        chk_reg("mask", 4'h2, 16'h003E);
        wr(4'h0, 16'h0001);
        chk_err(1'b0);
        chk_status(16'h8081, 16'hFFFF);
        wr(4'h0, 16'h8082);
        chk_err(1'b1);
        chk_status(16'h0002, 16'hFFFF);
        wr(4'hF, 16'hFFFF);
        chk_reg("unmapped", 4'hF, 16'h0000);
        cmd(4'h5, 3'h0, 80'h0, 2'h0, 6'h01, 4'h0);
        chk_err(1'b0);
    endtask : t_load
    task automatic t_codes();
        logic [15:0] cmp_exp [4] = '{16'h0000, 16'h0100, 16'h4000, 16'h4500};
        cmd(4'h1, 3'h0, va, 2'h0, 6'h00, 4'h0);
        for (int k = 0; k < 4; k++) begin
            cmd(4'h6, 3'h1, 80'h0, 2'h0, 6'h00, 4'(k));
            chk_status(cmp_exp[k], 16'h4500);
        end
        cmd(4'h7, 3'h0, 80'h0, 2'h0, 6'h00, 4'h8);
        chk_status(16'h0400, 16'h0400);
        cmd(4'h7, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        chk_status(16'h0000, 16'h4700);
        cmd(4'h7, 3'h0, 80'h0, 2'h0, 6'h00, 4'h7);
        chk_status(16'h4300, 16'h4700);
        cmd(4'h5, 3'h0, 80'h0, 2'h0, 6'h24, 4'hA);
        chk_status(16'h7A24, 16'hFFFF);
        cmd(4'hB, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        cmd(4'h8, 3'h0, 80'h0, 2'h0, 6'h00, 4'h2);
        chk_status(16'h4300, 16'h4700);
        cmd(4'hD, 3'h0, 80'h0, 2'h0, 6'h00, 4'h0);
        t_reset();
    endtask : t_codes

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // The run needs about 140 cycles; the limit of 3000 cycles is ample.
    initial begin
        #(25 * 3000);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        t_reset();
        t_stack();
        do_reset();
        t_fault();
        do_reset();
        t_load();
        do_reset();
        t_codes();
        give_verdict();
    end
endmodule : frss_top_test
